// ==== logic/sccc_regs.svh ====
// Purpose: Constants of the smart card coupler control block.
// Assumes: Main clock of 200 MHz.
// Notes: Command byte layout and step timing live here.
`ifndef SCCC_REGS_SVH
`define SCCC_REGS_SVH
`define SCCC_MCLK_MHZ 200
`define SCCC_CMD_ADDR_HI 7
`define SCCC_CMD_ADDR_LO 6
`define SCCC_CMD_RST_REL 5
`define SCCC_CMD_AUX_LOW 4
`define SCCC_CMD_ASYNC 3
`define SCCC_CMD_VSEL_HI 2
`define SCCC_CMD_VSEL_LO 1
`define SCCC_CMD_POWER 0
`define SCCC_ST_UV 4
`define SCCC_ST_FAULT 3
`define SCCC_ST_CARD 2
`define SCCC_ST_SUPPLY 1
`define SCCC_ST_AUX 0
`define SCCC_PD_STEP_NS 1000
`define SCCC_PD_STEP_CYC ((`SCCC_PD_STEP_NS * `SCCC_MCLK_MHZ + 999) / 1000)
`endif

// ==== logic/sccc_pkg.sv ====
// Purpose: Types of the smart card coupler control block.
// Assumes: Nothing beyond the constants header.
// Notes: Supply states are one-hot.
package sccc_pkg;
  typedef enum logic [4:0] {
    SUP_OFF = 5'h01,
    SUP_ON = 5'h02,
    SUP_PD_RST = 5'h04,
    SUP_PD_CLK = 5'h08,
    SUP_PD_VCC = 5'h10
  } sccc_sup_t;
endpackage

// ==== logic/sccc_top.sv ====
// Purpose: Control side of a smart card coupler with a chip-selected serial port.
// Assumes: Serial mode 0, MSB first; serial clock idles low and stops outside frames.
// Notes: The frame logic is reset by chip select high, the hold word by main reset; both run on the serial clock.
// How it works
// - Pullup on host data line connected while pullup enable input is high.
// - Status byte shifts out in the same frame the command shifts in.
// - Chip select frames each transfer; the command byte selects address and function.
// - Chip select high disables commands and card data transactions.
// - Undervoltage only sets a status bit; supply stays as programmed.
// - Overload turns supply off via power-down sequence and records a fault.
// - Aux line is open drain and reported in status bit zero.
// - Aux line read as positive logic; grounded reads zero.
// - Card-side signals are high only while the card supply is up.
// - Data translator enabled only when selected, asynchronous and chip select low.
// - Command byte carries one of four addresses plus programming code.
// - Interrupt output goes low on insertion, extraction or overload.
`timescale 1ns/100ps
`include "sccc_regs.svh"
module sccc_top
  import sccc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic spi_clk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic [1:0] chip_addr_i,
  input wire logic pullup_enable_input_i,
  input wire logic card_supply_undervoltage_i,
  input wire logic card_supply_overload_i,
  input wire logic card_present_i,
  input wire logic aux_card_line_high_i,
  output logic aux_card_line_high_o,
  output logic aux_card_line_high_oe_o,
  output logic pullup_connect_o,
  output logic io_xlat_en_o,
  output logic card_supply_en_o,
  output logic [1:0] card_supply_vsel_o,
  output logic card_reset_line_o,
  output logic card_clock_output_en_o,
  output logic int_n_o
);
  // ****************************************
  // Serial clock domain
  // ****************************************
  logic [7:0] rx_reg, rx_next, cmd_hold_reg, cmd_hold_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic cmd_tog_reg, cmd_tog_next;
  logic [7:0] st_s1_reg, st_s2_reg;
  logic [7:0] status_reg, status_next;
  logic [7:0] tx_reg, tx_next;
  logic miso_reg, miso_next, miso_oe_reg, miso_oe_next;

  always_comb begin
    rx_next = {rx_reg[6:0], mosi_i};
    bit_cnt_next = bit_cnt_reg + 3'h1;
    cmd_hold_next = cmd_hold_reg;
    cmd_tog_next = cmd_tog_reg;
    if (bit_cnt_reg == 3'h7) begin
      cmd_hold_next = rx_next;
      cmd_tog_next = ~cmd_tog_reg;
    end
  end

  // Chip select high resets the frame logic, so a broken frame never leaks a command.
  always_ff @(posedge spi_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rx_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else begin
      rx_reg <= rx_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // The hold word stays stable until the next frame completes, long after the toggle lands.
  // Main reset clears this side as well; the serial clock stands still while it is high.
  always_ff @(posedge spi_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_hold_reg <= 8'h00;
      cmd_tog_reg <= 1'b0;
      st_s1_reg <= 8'h00;
      st_s2_reg <= 8'h00;
    end else begin
      cmd_hold_reg <= cmd_hold_next;
      cmd_tog_reg <= cmd_tog_next;
      st_s1_reg <= status_reg;
      st_s2_reg <= st_s1_reg;
    end
  end

  always_comb begin
    miso_oe_next = 1'b1;
    if (!miso_oe_reg) begin
      miso_next = st_s2_reg[6];
      tx_next = {st_s2_reg[5:0], 2'h0};
    end else begin
      miso_next = tx_reg[7];
      tx_next = {tx_reg[6:0], 1'b0};
    end
  end

  // Bit seven is meaningless, so the line may stay released until the first falling edge.
  always_ff @(negedge spi_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else begin
      miso_reg <= miso_next;
      miso_oe_reg <= miso_oe_next;
      tx_reg <= tx_next;
    end
  end

  assign miso_o = miso_reg;
  assign miso_oe_o = miso_oe_reg;

  // ****************************************
  // Main clock domain
  // ****************************************
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] in_s1_reg, in_s2_reg;
  logic tog_s3_reg, cs_n_s2, pu_s2, uv_s2, ovl_s2, det_s2, aux_s2;
  logic [1:0] addr_s2;
  logic det_d_reg, ovl_d_reg, cmd_evt, cmd_hit;
  sccc_sup_t sup_reg, sup_next;
  logic [7:0] pd_cnt_reg, pd_cnt_next;
  logic sel_reg, sel_next, async_reg, async_next, rst_rel_reg, rst_rel_next;
  logic aux_low_reg, aux_low_next, uv_reg, uv_next, fault_reg, fault_next;
  logic [1:0] vsel_reg, vsel_next;
  logic int_n_reg, int_n_next, xlat_reg, xlat_next, pu_reg, sup_en_reg, sup_en_next;
  logic card_rst_reg, card_rst_next, clk_en_reg, clk_en_next, aux_oe_reg, aux_oe_next;

  always_ff @(posedge mclk_i) begin
    in_s1_reg <= {cmd_tog_reg, cs_n_i, pullup_enable_input_i, card_supply_undervoltage_i,
                  card_supply_overload_i, card_present_i, aux_card_line_high_i, chip_addr_i};
    in_s2_reg <= in_s1_reg;
  end

  assign {cs_n_s2, pu_s2, uv_s2, ovl_s2, det_s2, aux_s2, addr_s2} = in_s2_reg[7:0];
  assign cmd_evt = in_s2_reg[8] ^ tog_s3_reg;
  assign cmd_hit = cmd_evt && (cmd_hold_reg[`SCCC_CMD_ADDR_HI:`SCCC_CMD_ADDR_LO] == addr_s2);

  always_comb begin
    sup_next = sup_reg;
    pd_cnt_next = pd_cnt_reg;
    sel_next = sel_reg;
    async_next = async_reg;
    rst_rel_next = rst_rel_reg;
    aux_low_next = aux_low_reg;
    vsel_next = vsel_reg;
    if (cmd_evt) begin
      sel_next = cmd_hit;
    end
    if (cmd_hit) begin
      async_next = cmd_hold_reg[`SCCC_CMD_ASYNC];
      rst_rel_next = cmd_hold_reg[`SCCC_CMD_RST_REL];
      aux_low_next = cmd_hold_reg[`SCCC_CMD_AUX_LOW];
      vsel_next = cmd_hold_reg[`SCCC_CMD_VSEL_HI:`SCCC_CMD_VSEL_LO];
    end
    if (pd_cnt_reg != 8'h00) begin
      pd_cnt_next = pd_cnt_reg - 8'h01;
    end
    unique case (sup_reg)
      SUP_OFF: begin
        if (cmd_hit && cmd_hold_reg[`SCCC_CMD_POWER]) begin
          sup_next = SUP_ON;
        end
      end
      SUP_ON: begin
        // Undervoltage is deliberately absent here: recovery is up to the host.
        if (ovl_s2 || (cmd_hit && !cmd_hold_reg[`SCCC_CMD_POWER])) begin
          sup_next = SUP_PD_RST;
          pd_cnt_next = 8'(`SCCC_PD_STEP_CYC);
        end
      end
      SUP_PD_RST: begin
        if (pd_cnt_reg == 8'h00) begin
          sup_next = SUP_PD_CLK;
          pd_cnt_next = 8'(`SCCC_PD_STEP_CYC);
        end
      end
      SUP_PD_CLK: begin
        if (pd_cnt_reg == 8'h00) begin
          sup_next = SUP_PD_VCC;
          pd_cnt_next = 8'(`SCCC_PD_STEP_CYC);
        end
      end
      SUP_PD_VCC: begin
        if (pd_cnt_reg == 8'h00) begin
          sup_next = SUP_OFF;
        end
      end
    endcase
    sup_en_next = (sup_next != SUP_OFF) && (sup_next != SUP_PD_VCC);
    card_rst_next = (sup_next == SUP_ON) && rst_rel_next;
    clk_en_next = (sup_next == SUP_ON) || (sup_next == SUP_PD_RST);
    aux_oe_next = (sup_next == SUP_ON) && !async_next && aux_low_next;
    xlat_next = !cs_n_s2 && sel_next && async_next && (sup_next == SUP_ON);
    // Hardware events win over the clear carried by an addressed command.
    uv_next = uv_s2 || (uv_reg && !cmd_hit);
    fault_next = (ovl_s2 && !ovl_d_reg) || (fault_reg && !cmd_hit);
    int_n_next = int_n_reg || cmd_hit;
    if ((det_s2 != det_d_reg) || (ovl_s2 && !ovl_d_reg)) begin
      int_n_next = 1'b0;
    end
    status_next = {3'h0, uv_next, fault_next, det_s2, sup_en_next, aux_s2};
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tog_s3_reg <= 1'b0;
      sup_reg <= SUP_OFF;
      pd_cnt_reg <= 8'h00;
      sel_reg <= 1'b0;
      async_reg <= 1'b0;
      rst_rel_reg <= 1'b0;
      aux_low_reg <= 1'b0;
      vsel_reg <= 2'h0;
      uv_reg <= 1'b0;
      fault_reg <= 1'b0;
      int_n_reg <= 1'b1;
      det_d_reg <= 1'b0;
      ovl_d_reg <= 1'b0;
      xlat_reg <= 1'b0;
      pu_reg <= 1'b0;
      sup_en_reg <= 1'b0;
      card_rst_reg <= 1'b0;
      clk_en_reg <= 1'b0;
      aux_oe_reg <= 1'b0;
      status_reg <= 8'h00;
    end else begin
      tog_s3_reg <= in_s2_reg[8];
      sup_reg <= sup_next;
      pd_cnt_reg <= pd_cnt_next;
      sel_reg <= sel_next;
      async_reg <= async_next;
      rst_rel_reg <= rst_rel_next;
      aux_low_reg <= aux_low_next;
      vsel_reg <= vsel_next;
      uv_reg <= uv_next;
      fault_reg <= fault_next;
      int_n_reg <= int_n_next;
      det_d_reg <= det_s2;
      ovl_d_reg <= ovl_s2;
      xlat_reg <= xlat_next;
      pu_reg <= pu_s2;
      sup_en_reg <= sup_en_next;
      card_rst_reg <= card_rst_next;
      clk_en_reg <= clk_en_next;
      aux_oe_reg <= aux_oe_next;
      status_reg <= status_next;
    end
  end

  assign aux_card_line_high_o = 1'b0;
  assign aux_card_line_high_oe_o = aux_oe_reg;
  assign pullup_connect_o = pu_reg;
  assign io_xlat_en_o = xlat_reg;
  assign card_supply_en_o = sup_en_reg;
  assign card_supply_vsel_o = vsel_reg;
  assign card_reset_line_o = card_rst_reg;
  assign card_clock_output_en_o = clk_en_reg;
  assign int_n_o = int_n_reg;

  // ****************************************
  // Checks
  // ****************************************
  chk_pullup_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
    ##1 (pullup_connect_o == $past(pu_s2))) else $error("pullup does not follow enable");
  chk_xlat_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    io_xlat_en_o |-> $past(!cs_n_s2 && async_next && sel_next)) else $error("translator gate");
  chk_cs_high_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    cs_n_s2 |=> !io_xlat_en_o) else $error("translator on while deselected");
  chk_ovl_shutdown: assert property (@(posedge mclk_i) disable iff (reset_i)
    (sup_reg == SUP_ON && ovl_s2 && !ovl_d_reg) |=> (sup_reg == SUP_PD_RST) && fault_reg
    ##[1:700] !card_supply_en_o) else $error("overload did not power down");
  chk_uv_nostop: assert property (@(posedge mclk_i) disable iff (reset_i)
    (sup_reg == SUP_ON && uv_s2 && !ovl_s2 && !cmd_evt) |=> (sup_reg == SUP_ON) && uv_reg)
    else $error("undervoltage changed supply");
  chk_int_event: assert property (@(posedge mclk_i) disable iff (reset_i)
    (det_s2 != det_d_reg) |=> !int_n_o) else $error("no interrupt on card event");
  chk_miso_hiz: assert property (@(posedge mclk_i) disable iff (reset_i)
    cs_n_i |-> !miso_oe_o) else $error("serial output driven while deselected");
  chk_card_levels: assert property (@(posedge mclk_i) disable iff (reset_i)
    (card_reset_line_o || aux_card_line_high_oe_o) |-> card_supply_en_o)
    else $error("card signal without supply");
  chk_status_top: assert property (@(posedge mclk_i) disable iff (reset_i)
    status_reg[7:5] == 3'h0 && (status_reg[0] == $past(aux_s2))) else $error("status layout");
  chk_frame_cmd: assert property (@(negedge spi_clk_i) disable iff (cs_n_i)
    ($past(bit_cnt_reg) == 3'h7) |-> (cmd_tog_reg != $past(cmd_tog_reg)))
    else $error("frame lost");
endmodule

// ==== verification/sccc_host_model.sv ====
// Purpose: Host microcontroller model for the serial control port.
// Assumes: Mode 0, MSB first, serial clock of 6 ns period.
// Notes: The serial clock stands low outside frames.
`timescale 1ns/100ps
module sccc_host_model (
  output logic spi_clk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    spi_clk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  task automatic select(input logic v);
    #1.7 cs_n_o = v;
  endtask
  // A short count of bits aborts the frame, which the coupler must discard.
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [7:0] st);
    #1.7 cs_n_o = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = cmd[i];
      #3 spi_clk_o = 1'b1;
      st[i] = miso_i;
      #3 spi_clk_o = 1'b0;
    end
    #3 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    st[7:5] = 3'h0;
  endtask
endmodule

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the coupler control block.
// Assumes: This coupler is strapped to address 1.
// Notes: Status is read with a second frame because it is one frame stale.
`timescale 1ns/100ps
module testbench;
  logic mclk, reset, pue, uv, ov, card, aux_gnd;
  logic spi_clk, cs_n, mosi, miso, miso_oe, aux_o, aux_oe, pull, xlat;
  logic sup_en, card_rst, clk_en, int_n;
  logic [1:0] vsel;
  logic [7:0] st;
  int n_fail = 0;
  int tests_run = 0;
  wire miso_line = miso_oe ? miso : 1'b0;
  wire aux_line = !aux_oe && !aux_gnd && sup_en;
  // ****************************************
  // Instances and clocks
  // ****************************************
  sccc_top i_sccc_top (.mclk_i(mclk), .reset_i(reset), .spi_clk_i(spi_clk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .chip_addr_i(2'h1),
    .pullup_enable_input_i(pue), .card_supply_undervoltage_i(uv),
    .card_supply_overload_i(ov), .card_present_i(card), .aux_card_line_high_i(aux_line),
    .aux_card_line_high_o(aux_o), .aux_card_line_high_oe_o(aux_oe), .pullup_connect_o(pull),
    .io_xlat_en_o(xlat), .card_supply_en_o(sup_en), .card_supply_vsel_o(vsel),
    .card_reset_line_o(card_rst), .card_clock_output_en_o(clk_en), .int_n_o(int_n));
  sccc_host_model i_sccc_host_model (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso_line));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic send(input logic [7:0] cmd);
    i_sccc_host_model.xfer(cmd, 8, st);
    cyc(10);
  endtask
  task automatic poll;
    send(8'h00);
    send(8'h00);
  endtask
  task automatic results;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pullup;
    for (int v = 0; v < 2; v++) begin
      @(posedge mclk) pue <= v[0];
      cyc(6);
      check(pull, v[0]);
    end
  endtask
  task automatic t_power;
    send(8'h2d);
    check(sup_en, 1'b0);
    send(8'h6d);
    check(sup_en, 1'b1);
    check(vsel, 2'h2);
    check(card_rst, 1'b1);
    check(clk_en, 1'b1);
    i_sccc_host_model.xfer(8'h40, 4, st);
    cyc(10);
    check(sup_en, 1'b1);
    poll;
    check(st, 8'h03);
  endtask
  task automatic t_aux;
    send(8'h75);
    check(aux_oe, 1'b1);
    check(aux_o, 1'b0);
    poll;
    check(st, 8'h02);
    send(8'h6d);
    @(posedge mclk) aux_gnd <= 1'b1;
    poll;
    check(st, 8'h02);
    @(posedge mclk) aux_gnd <= 1'b0;
  endtask
  task automatic t_xlat;
    send(8'h6d);
    i_sccc_host_model.select(1'b0);
    cyc(8);
    check(xlat, 1'b1);
    i_sccc_host_model.select(1'b1);
    cyc(8);
    check(xlat, 1'b0);
    check(miso_oe, 1'b0);
    send(8'h00);
    i_sccc_host_model.select(1'b0);
    cyc(8);
    check(xlat, 1'b0);
    i_sccc_host_model.select(1'b1);
    cyc(8);
  endtask
  task automatic t_uv;
    @(posedge mclk) uv <= 1'b1;
    cyc(5);
    @(posedge mclk) uv <= 1'b0;
    poll;
    check(st, 8'h13);
    check(sup_en, 1'b1);
    send(8'h6d);
    poll;
    check(st, 8'h03);
  endtask
  task automatic t_ovl;
    @(posedge mclk) ov <= 1'b1;
    cyc(8);
    check(int_n, 1'b0);
    check(card_rst, 1'b0);
    check(sup_en, 1'b1);
    cyc(250);
    check(clk_en, 1'b0);
    check(sup_en, 1'b1);
    cyc(200);
    check(sup_en, 1'b0);
    @(posedge mclk) ov <= 1'b0;
    poll;
    check(st, 8'h08);
  endtask
  task automatic t_card;
    send(8'h40);
    check(int_n, 1'b1);
    @(posedge mclk) card <= 1'b1;
    cyc(8);
    check(int_n, 1'b0);
    poll;
    check(st, 8'h04);
  endtask
  // Reset rises after time zero so that the serial side's edge-triggered reset sees it.
  initial begin
    pue = 1'b0;
    uv = 1'b0;
    ov = 1'b0;
    card = 1'b0;
    aux_gnd = 1'b0;
    #1 reset = 1'b1;
    cyc(7);
    @(posedge mclk) reset <= 1'b0;
    cyc(4);
    t_pullup;
    t_power;
    t_aux;
    t_xlat;
    t_uv;
    t_ovl;
    t_card;
    results;
  end
  initial begin
    #60000;
    n_fail++;
    results;
  end
endmodule
